//--- verilog/pdl_pkg.sv
// Constants for the first tracking loop pull-in limit register bank
package pdl_pkg;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  LIM_LOW_IDX   = 8'h41;
	localparam logic [7:0]  LIM_HIGH_IDX  = 8'h42;
	localparam int          APB_ADDR_W    = 12;
	localparam logic [11:0] LIM_LOW_ADDR  = {2'h0, LIM_LOW_IDX, 2'h0};
	localparam logic [11:0] LIM_HIGH_ADDR = {2'h0, LIM_HIGH_IDX, 2'h0};
	// Field layout
	localparam int          LIMIT_W       = 10;
	localparam int          LIM_LOW_W     = 8;
	localparam int          LIM_HIGH_W    = 2;
	localparam int          LIM_HIGH_LSB  = 8;
	localparam int          LIM_HIGH_MSB  = 9;
	localparam int          APB_DATA_W    = 32;
	localparam int          OFS_W_MIN     = LIMIT_W + 2;
	// Reset values
	localparam logic [1:0]  LIM_HIGH_RST  = 2'h3;
	localparam logic [7:0]  LIM_LOW_RST   = 8'h00;
	localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
endpackage

//--- verilog/pdl_sym_clamp.sv
// Symmetric clamp of a signed offset to plus or minus an unsigned limit
`timescale 1ns/1ps
module pdl_sym_clamp #(
	parameter int W      = 17,
	parameter int LIM_W  = 10
)(
	// Offset in
	input  wire logic signed [W-1:0]     offsetIn,
	// Magnitude limit
	input  wire logic        [LIM_W-1:0] limit,
	// Clamped result
	output logic signed      [W-1:0]     offsetOut,
	output logic                         clamped
);
	initial
	begin
		if (W < LIM_W + 2)
			$error("pdl_sym_clamp: W too small for the limit");
	end

	// Limit widened with a zero sign bit so both bounds are exact
	wire logic signed [W-1:0] posBound = $signed({{(W-LIM_W){1'b0}}, limit});
	wire logic signed [W-1:0] negBound = -posBound;
	wire logic                overPos  = offsetIn > posBound;
	wire logic                underNeg = offsetIn < negBound;

	assign offsetOut = overPos ? posBound : (underNeg ? negBound : offsetIn);
	assign clamped   = overPos | underNeg;
endmodule

//--- verilog/pdl_pullin_limit_regs.sv
// Pull-in limit registers and offset clamp of the first tracking loop, APB slave
//
// Operation
// - The loop follows the source offset only up to the programmed limit and is clamped beyond it.
// - The limit is a 10-bit unsigned value, high register bits [1:0] on top of low register bits [7:0].
// - The one limit bounds positive and negative offsets by the same magnitude.
// - The offset is taken against the crystal with the nominal-frequency calibration added in.
// - The high limit register is read/write, holds limit bits 9:8 low, and resets to 0000 0011.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module pdl_pullin_limit_regs #(
	parameter int         OFS_W   = 16,
	parameter logic [7:0] LOW_RST = pdl_pkg::LIM_LOW_RST
)(
	// Clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          sys_rst,
	// APB slave
	input  wire logic [pdl_pkg::APB_ADDR_W-1:0] paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [pdl_pkg::APB_DATA_W-1:0] pwdata,
	input  wire logic [3:0]                    pstrb,
	output logic      [pdl_pkg::APB_DATA_W-1:0] prdata,
	output logic                               pready,
	output logic                               pslverr,
	// Offset measurement from the loop
	input  wire logic signed [OFS_W-1:0]       rawOffset,
	input  wire logic signed [OFS_W-1:0]       calOffset,
	input  wire logic                          offsetValid,
	// Tracking result and limit
	output logic signed [OFS_W:0]              trackOffset,
	output logic                               trackClamped,
	output logic                               trackValid,
	output logic [pdl_pkg::LIMIT_W-1:0]        loopPullinLimit
);
	initial
	begin
		if (OFS_W < pdl_pkg::OFS_W_MIN)
			$error("pdl_pullin_limit_regs: OFS_W below minimum");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register storage and APB decode

	logic [pdl_pkg::LIM_LOW_W-1:0]  limLowReg;
	logic [pdl_pkg::LIM_HIGH_W-1:0] limHighReg;
	logic                           preadyReg;
	logic                           pslverrReg;
	logic [pdl_pkg::APB_DATA_W-1:0] prdataReg;

	wire logic accessPhase = psel & penable;
	// Answer one cycle into the access phase, so pready is a flop
	wire logic answering   = accessPhase & ~preadyReg;
	wire logic completing  = accessPhase & preadyReg;
	wire logic hitLow      = paddr == pdl_pkg::LIM_LOW_ADDR;
	wire logic hitHigh     = paddr == pdl_pkg::LIM_HIGH_ADDR;
	wire logic hitAny      = hitLow | hitHigh;
	wire logic wrLow       = completing & pwrite & hitLow & pstrb[0];
	wire logic wrHigh      = completing & pwrite & hitHigh & pstrb[0];

	wire logic [7:0] highView = {6'h00, limHighReg};
	wire logic [7:0] readMux  = hitLow ? limLowReg : (hitHigh ? highView : 8'h00);
	wire logic [pdl_pkg::APB_DATA_W-1:0] rdataNext = {24'h000000, readMux};

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			preadyReg  <= 1'b0;
			pslverrReg <= 1'b0;
			prdataReg  <= pdl_pkg::RDATA_ZERO;
		end
		else
		begin
			preadyReg  <= answering;
			pslverrReg <= answering & ~hitAny;
			if (answering)
				prdataReg <= pwrite ? pdl_pkg::RDATA_ZERO : rdataNext;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			limHighReg <= pdl_pkg::LIM_HIGH_RST;
		else if (wrHigh)
			limHighReg <= pwdata[pdl_pkg::LIM_HIGH_W-1:0];
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			limLowReg <= LOW_RST;
		else if (wrLow)
			limLowReg <= pwdata[pdl_pkg::LIM_LOW_W-1:0];
	end

	assign prdata  = prdataReg;
	assign pready  = preadyReg;
	assign pslverr = pslverrReg;

	////////////////////////////////////////////////////////////////////////////////
	// Limit word and offset clamp

	wire logic [pdl_pkg::LIMIT_W-1:0] limitWord = {limHighReg, limLowReg};

	// add calibration
	// One extra bit keeps the sum of two full-scale offsets from wrapping
	wire logic signed [OFS_W:0] netOffset =
		$signed({rawOffset[OFS_W-1], rawOffset}) + $signed({calOffset[OFS_W-1], calOffset});

	wire logic signed [OFS_W:0] clampOut;
	wire logic                  clampHit;

	pdl_sym_clamp #(
		.W      (OFS_W + 1),
		.LIM_W  (pdl_pkg::LIMIT_W)
	) uClamp (
		.offsetIn  (netOffset),
		.limit     (limitWord),
		.offsetOut (clampOut),
		.clamped   (clampHit)
	);

	logic signed [OFS_W:0]            trackOffsetReg;
	logic                             trackClampedReg;
	logic                             trackValidReg;
	logic [pdl_pkg::LIMIT_W-1:0]      limitOutReg;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			trackOffsetReg  <= '0;
			trackClampedReg <= 1'b0;
			trackValidReg   <= 1'b0;
			limitOutReg     <= {pdl_pkg::LIM_HIGH_RST, pdl_pkg::LIM_LOW_RST};
		end
		else
		begin
			trackValidReg <= offsetValid;
			limitOutReg   <= limitWord;
			// Result holds between measurements so the loop sees a steady value
			if (offsetValid)
			begin
				trackOffsetReg  <= clampOut;
				trackClampedReg <= clampHit;
			end
		end
	end

	assign trackOffset     = trackOffsetReg;
	assign trackClamped    = trackClampedReg;
	assign trackValid      = trackValidReg;
	assign loopPullinLimit = limitOutReg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	wire logic signed [OFS_W:0] limitSigned = $signed({{(OFS_W+1-pdl_pkg::LIMIT_W){1'b0}}, limitWord});
	wire logic signed [OFS_W:0] limitNeg    = -limitSigned;

	sequence seqHighWrite;
		psel && penable && pready && pwrite && paddr == pdl_pkg::LIM_HIGH_ADDR && pstrb[0];
	endsequence

	sequence seqHighRead;
		psel && penable && pready && !pwrite && paddr == pdl_pkg::LIM_HIGH_ADDR;
	endsequence

	chk_clamp_bound: assert property (
		offsetValid |=> trackOffset <= $past(limitSigned) && trackOffset >= $past(limitNeg))
	else
		$error("tracked offset left the pull-in range");

	chk_limit_order: assert property (
		seqHighWrite ##0 (!wrLow) |=> ##1 loopPullinLimit[pdl_pkg::LIM_HIGH_MSB:pdl_pkg::LIM_HIGH_LSB]
			== $past(pwdata[1:0], 2))
	else
		$error("high register bits not on top of limit");

	chk_neg_clamp: assert property (
		offsetValid && netOffset < limitNeg |=> trackClamped && trackOffset == -$past(limitSigned))
	else
		$error("negative offset not clamped at minus limit");

	// Expected sum built from the ports, so dropping the calibration term is caught
	chk_cal_included: assert property (
		offsetValid && !clampHit |=>
			trackOffset == $past(rawOffset) + $past(calOffset) && !trackClamped)
	else
		$error("calibration not included in offset");

	chk_high_reset: assert property (
		$fell(sys_rst) |-> limHighReg == pdl_pkg::LIM_HIGH_RST && loopPullinLimit[9:8] == 2'h3)
	else
		$error("high limit register reset value wrong");

	chk_high_readback: assert property (
		seqHighRead |-> prdata[31:2] == 30'h00000000 && prdata[1:0] == limHighReg)
	else
		$error("high register read shows unused bits");

	chk_slverr_map: assert property (
		psel && penable && pready |-> pslverr == !(hitLow || hitHigh))
	else
		$error("error answer does not match address map");

	chk_low_write: assert property (
		psel && penable && pready && pwrite && paddr == pdl_pkg::LIM_LOW_ADDR && pstrb[0]
			|=> limLowReg == $past(pwdata[pdl_pkg::LIM_LOW_W-1:0]))
	else
		$error("low limit register write lost");

	chk_pos_clamp: assert property (
		offsetValid && (rawOffset + calOffset) > limitSigned
			|=> trackClamped && trackOffset == $past(limitSigned))
	else
		$error("positive offset not clamped at plus limit");
endmodule

//--- dv/pdl_pullin_limit_regs_tb_top.sv
// Self-checking bench for the pull-in limit register bank
`timescale 1ns/1ps
module pdl_pullin_limit_regs_tb_top;
	logic               core_clk;
	logic               sys_rst;
	logic [11:0]        paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [31:0]        pwdata;
	logic [3:0]         pstrb;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic signed [15:0] rawOffset;
	logic signed [15:0] calOffset;
	logic               offsetValid;
	logic signed [16:0] trackOffset;
	logic               trackClamped;
	logic               trackValid;
	logic [9:0]         loopPullinLimit;
	logic [9:0]         lim;
	logic [31:0]        rd;
	logic               err;
	logic [15:0]        lfsr;
	int                 nFail;
	int                 checkCount;
	localparam logic [11:0] LO = pdl_pkg::LIM_LOW_ADDR;
	localparam logic [11:0] HI = pdl_pkg::LIM_HIGH_ADDR;

	pdl_pullin_limit_regs u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rawOffset(rawOffset),
		.calOffset(calOffset), .offsetValid(offsetValid), .trackOffset(trackOffset),
		.trackClamped(trackClamped), .trackValid(trackValid),
		.loopPullinLimit(loopPullinLimit));

////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			nFail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Request held until pready is seen at a rising edge; no latency assumed
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			nFail++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic ofs(input logic [15:0] r, input logic [15:0] c);
		logic signed [16:0] s;
		logic signed [16:0] m;
		@(posedge core_clk);
		rawOffset <= r;
		calOffset <= c;
		offsetValid <= 1'b1;
		@(posedge core_clk);
		offsetValid <= 1'b0;
		#1;
		s = {r[15], r} + {c[15], c};
		m = {7'h00, lim};
		chk(trackValid, 32'h1);
		chk(trackOffset, (s > m) ? m : (s < -m) ? -m : s);
		chk(trackClamped, (s > m) || (s < -m));
	endtask

////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		repeat (100000) @(posedge core_clk);
		nFail++;
		end_sim();
	end

	initial
	begin
		{sys_rst, psel, penable, pwrite, offsetValid} = 5'h10;
		{paddr, pwdata, rawOffset, calOffset} = '0;
		pstrb = 4'hF;
		lfsr = 16'h0038;
		nFail = 0;
		checkCount = 0;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		#1 chk(loopPullinLimit, 32'h300);
		apb(HI, 1'b0, 32'h0);
		chk(rd, 32'h3);
		apb(LO, 1'b0, 32'h0);
		chk(rd, {24'h0, pdl_pkg::LIM_LOW_RST});
		// Unmapped word must flag an error and leave the bank alone
		apb(12'hFFC, 1'b1, 32'h55);
		chk(err, 32'h1);
		apb(12'hFFC, 1'b0, 32'h0);
		chk(rd, 32'h0);
		// Byte lane 0 off: the write must not land
		pstrb <= 4'h0;
		apb(HI, 1'b1, 32'h0);
		pstrb <= 4'hF;
		apb(HI, 1'b0, 32'h0);
		chk(rd, 32'h3);
		chk(err, 32'h0);
		$display("reset and decode test done");
		// Corners first: zero limit, then the full 10-bit limit
		for (int k = 0; k < 10; k++)
		begin
			lfsr = nxt(lfsr);
			lim = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : lfsr[9:0];
			apb(LO, 1'b1, {16'hA5A5, lfsr[15:8], lim[7:0]});
			apb(HI, 1'b1, {lfsr, lfsr[15:2], lim[9:8]});
			apb(HI, 1'b0, 32'h0);
			chk(rd, {30'h0, lim[9:8]});
			chk(err, 32'h0);
			apb(LO, 1'b0, 32'h0);
			chk(rd, {24'h0, lim[7:0]});
			chk(loopPullinLimit, lim);
			ofs(lim, 16'h0000);
			ofs(lim + 1, 16'h0000);
			ofs(-lim, 16'h0000);
			ofs(-lim - 1, 16'h0000);
			ofs(lim, 16'h0001);
			lfsr = nxt(lfsr);
			ofs({{5{lfsr[10]}}, lfsr[10:0]}, {{9{lfsr[15]}}, lfsr[15:9]});
		end
		$display("limit and clamp test done");
		end_sim();
	end
endmodule
